// ### hw/psmc_map.vh
`ifndef PSMC_MAP_VH
`define PSMC_MAP_VH

// ************************************************************
// Register offsets (I2C address space)
// ************************************************************
`define PSMC_IO_SETUP_OFS      8'hF5
`define PSMC_MEAS_CTRL_OFS     8'hF4
`define PSMC_STATUS_OFS        8'hF3

// ************************************************************
// Interface-setup field positions
// ************************************************************
`define PSMC_STBY_MSB          7
`define PSMC_STBY_LSB          5
`define PSMC_OUT_TYPE_BIT      2
`define PSMC_WIRE_MODE_BIT     0

// ************************************************************
// Measurement-control field positions
// ************************************************************
`define PSMC_TAVG_MSB          7
`define PSMC_TAVG_LSB          5
`define PSMC_PAVG_MSB          4
`define PSMC_PAVG_LSB          2
`define PSMC_MODE_MSB          1
`define PSMC_MODE_LSB          0

// ************************************************************
// Status field positions
// ************************************************************
`define PSMC_MEASURING_BIT     3
`define PSMC_NVM_BUSY_BIT      0

// ************************************************************
// Reset values and bus addresses
// ************************************************************
`define PSMC_IO_SETUP_RST      8'h00
`define PSMC_MEAS_CTRL_RST     8'h00
`define PSMC_FILTER_RST        3'h0
`define PSMC_I2C_ADDR_LOW      7'h70
`define PSMC_I2C_ADDR_HIGH     7'h56

// ************************************************************
// Timing
// ************************************************************
`define PSMC_CLK_PERIOD_NS     10
`define PSMC_TICK_NS           1000
`define PSMC_TICK_CYCLES       8'h64

`endif

// ### hw/psmc_mode_control.v
// What this block does
// - Chip-select high selects I2C port mode
// - Chip-select low selects SPI port mode
// - SPI stays latched until any reset
// - Any reset returns port to I2C
// - I2C address 70h or 56h by pin
// - Wire-mode bit picks 3-wire or 4-wire SPI
// - Sleep, normal, forced modes via control register
// - Sleep mode runs no conversions
// - Registers stay writable and readable in sleep
// - Forced: one measurement, store, back to sleep
// - Normal: measurement and standby alternate forever
// - Standby length from three-bit field
// - Five oversampling pairs 2/1 to 32/4
// - IIR filter off to 32, off at start
// - Interface setup: standby, output type, wire mode
// - Control: temp avg, pressure avg, power mode
// - Status: measuring bit 3, memory bit 0
`timescale 1ns/1ps
`default_nettype none
`include "psmc_map.vh"

module psmc_mode_control #(
	parameter [1:0]  MODE_SLEEP     = 2'h0,
	parameter [1:0]  MODE_FORCED    = 2'h1,
	parameter [1:0]  MODE_NORMAL    = 2'h3,
	parameter [15:0] SAMPLE_TICKS   = 16'h0064,
	parameter [15:0] STBY_BASE_TICKS = 16'h0001,
	parameter [7:0]  TICK_CYCLES    = `PSMC_TICK_CYCLES
) (
	// Clock and reset
	input  wire       i_ref_clk,
	input  wire       i_rst,
	// Device pins
	input  wire       i_async_rst_pin_n,
	input  wire       i_chip_select_pin,
	input  wire       i_addr_select_dout_pin,
	// Register writes from the serial front end
	input  wire       i_io_setup_wr,
	input  wire [7:0] i_io_setup_data,
	input  wire       i_meas_ctrl_wr,
	input  wire [7:0] i_meas_ctrl_data,
	input  wire       i_filter_wr,
	input  wire [2:0] i_filter_data,
	// Calibration memory access in progress
	input  wire       i_nvm_access,
	// Port mode
	output reg        o_spi_mode,
	output reg        o_spi_3wire,
	output reg        o_data_pin_output_type,
	output reg  [6:0] o_i2c_addr,
	// Register images
	output reg  [7:0] o_io_setup_reg,
	output reg  [7:0] o_measurement_control_reg,
	output reg  [7:0] o_status_reg,
	output reg  [2:0] o_filter_coef,
	// Conversion control
	output reg        o_conv_active,
	output reg  [5:0] o_press_samples,
	output reg  [2:0] o_temp_samples,
	output reg        o_result_store
);

	// ************************************************************
	// Oversampling table
	// ************************************************************
	// Pressure samples per setting code, zero means skip
	function [5:0] psmc_press_os;
		input [2:0] code;
		begin
			case (code)
				3'h1: psmc_press_os = 6'h02;
				3'h2: psmc_press_os = 6'h04;
				3'h3: psmc_press_os = 6'h08;
				3'h4: psmc_press_os = 6'h10;
				3'h5: psmc_press_os = 6'h20;
				default: psmc_press_os = 6'h00;
			endcase
		end
	endfunction

	// Temperature samples paired with each setting
	function [2:0] psmc_temp_os;
		input [2:0] code;
		begin
			case (code)
				3'h1, 3'h2, 3'h3: psmc_temp_os = 3'h1;
				3'h4: psmc_temp_os = 3'h2;
				3'h5: psmc_temp_os = 3'h4;
				default: psmc_temp_os = 3'h0;
			endcase
		end
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	reg  [2:0] cs_sync;
	reg  [2:0] addr_sync;
	reg  [2:0] arst_sync;
	reg        cs_level;
	reg        addr_level;
	reg        arst_level_n;
	wire       any_rst;

	// Three stages; a level counts once stages two and three agree
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			cs_sync      <= 3'h7;
			addr_sync    <= 3'h0;
			arst_sync    <= 3'h7;
			cs_level     <= 1'b1;
			addr_level   <= 1'b0;
			arst_level_n <= 1'b1;
		end else begin
			cs_sync   <= {cs_sync[1:0], i_chip_select_pin};
			addr_sync <= {addr_sync[1:0], i_addr_select_dout_pin};
			arst_sync <= {arst_sync[1:0], i_async_rst_pin_n};
			if (cs_sync[1] == cs_sync[2])
				cs_level <= cs_sync[2];
			if (addr_sync[1] == addr_sync[2])
				addr_level <= addr_sync[2];
			if (arst_sync[1] == arst_sync[2])
				arst_level_n <= arst_sync[2];
		end
	end

	// The pin reset acts as a second power-on reset
	assign any_rst = i_rst | ~arst_level_n;

	// ************************************************************
	// Port mode selection
	// ************************************************************
	// SPI is sticky: a later high chip select never undoes it
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_spi_mode <= 1'b0;
		end else if (!cs_level) begin
			o_spi_mode <= 1'b1;
		end
	end

	// Address follows the pin only while in I2C mode
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_i2c_addr <= `PSMC_I2C_ADDR_LOW;
		end else if (!o_spi_mode) begin
			o_i2c_addr <= addr_level ? `PSMC_I2C_ADDR_HIGH : `PSMC_I2C_ADDR_LOW;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	reg        mode_wr;
	reg  [1:0] mode_wr_val;
	reg        forced_done;

	// Writes are taken in every power state, sleep included
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_io_setup_reg <= `PSMC_IO_SETUP_RST;
			o_filter_coef  <= `PSMC_FILTER_RST;
		end else begin
			if (i_io_setup_wr)
				o_io_setup_reg <= i_io_setup_data;
			if (i_filter_wr)
				o_filter_coef <= (i_filter_data > 3'h5) ? 3'h0 : i_filter_data;
		end
	end

	// Forced completion rewrites the mode field to sleep
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_measurement_control_reg <= `PSMC_MEAS_CTRL_RST;
		end else if (i_meas_ctrl_wr) begin
			o_measurement_control_reg <= i_meas_ctrl_data;
		end else if (forced_done) begin
			o_measurement_control_reg[`PSMC_MODE_MSB:`PSMC_MODE_LSB] <= MODE_SLEEP;
		end
	end

	// Register the mode write so the sequencer sees it next cycle
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			mode_wr     <= 1'b0;
			mode_wr_val <= MODE_SLEEP;
		end else begin
			mode_wr     <= i_meas_ctrl_wr;
			mode_wr_val <= i_meas_ctrl_data[`PSMC_MODE_MSB:`PSMC_MODE_LSB];
		end
	end

	// Derived port outputs
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_spi_3wire            <= 1'b0;
			o_data_pin_output_type <= 1'b0;
		end else begin
			o_spi_3wire <= o_spi_mode & o_io_setup_reg[`PSMC_WIRE_MODE_BIT];
			o_data_pin_output_type <= o_io_setup_reg[`PSMC_OUT_TYPE_BIT];
		end
	end

	// ************************************************************
	// Time base
	// ************************************************************
	reg  [7:0] tick_cnt;
	reg        tick;

	// One-cycle enable each microsecond keeps the long timers narrow
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			tick_cnt <= 8'h00;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES - 8'h01) begin
			tick_cnt <= 8'h00;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 8'h01;
			tick     <= 1'b0;
		end
	end

	// ************************************************************
	// Power sequencer
	// ************************************************************
	localparam [1:0] ST_SLEEP   = 2'h0;
	localparam [1:0] ST_MEASURE = 2'h1;
	localparam [1:0] ST_STANDBY = 2'h2;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg         normal_run;
	reg  [23:0] timer;
	reg  [23:0] next_timer;
	reg  [2:0]  pavg;
	reg  [23:0] meas_ticks;
	reg  [23:0] stby_ticks;
	reg         meas_end;

	// Measurement length scales with the total sample count
	always @* begin
		pavg = o_measurement_control_reg[`PSMC_PAVG_MSB:`PSMC_PAVG_LSB];
		meas_ticks = {8'h00, SAMPLE_TICKS} *
			{18'h00000, psmc_press_os(pavg) + {3'h0, psmc_temp_os(pavg)}};
		stby_ticks = {8'h00, STBY_BASE_TICKS} <<
			o_io_setup_reg[`PSMC_STBY_MSB:`PSMC_STBY_LSB];
		meas_end = (state == ST_MEASURE) && tick && (timer == 24'h000000);
	end

	// Next state: a sleep, forced or normal mode write wins over the running timers
	always @* begin
		next_state = state;
		next_timer = timer;
		if (mode_wr && mode_wr_val == MODE_SLEEP) begin
			next_state = ST_SLEEP;
		end else if (mode_wr && (mode_wr_val == MODE_FORCED || mode_wr_val == MODE_NORMAL)) begin
			next_state = ST_MEASURE;
			next_timer = meas_ticks;
		end else begin
			case (state)
				ST_SLEEP: begin
					next_state = ST_SLEEP;
				end
				ST_MEASURE: begin
					if (tick && timer != 24'h000000)
						next_timer = timer - 24'h000001;
					if (meas_end) begin
						next_state = normal_run ? ST_STANDBY : ST_SLEEP;
						next_timer = stby_ticks;
					end
				end
				ST_STANDBY: begin
					if (tick && timer != 24'h000000) begin
						next_timer = timer - 24'h000001;
					end else if (tick) begin
						next_state = ST_MEASURE;
						next_timer = meas_ticks;
					end
				end
				default: begin
					next_state = ST_SLEEP;
				end
			endcase
		end
	end

	// Sequencer registers
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			state       <= ST_SLEEP;
			timer       <= 24'h000000;
			normal_run  <= 1'b0;
			forced_done <= 1'b0;
		end else begin
			state       <= next_state;
			timer       <= next_timer;
			forced_done <= meas_end && !normal_run && !mode_wr;
			if (mode_wr)
				normal_run <= (mode_wr_val == MODE_NORMAL);
		end
	end

	// ************************************************************
	// Conversion outputs and status
	// ************************************************************
	// Results are only stored; the host fetches them itself
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_conv_active   <= 1'b0;
			o_press_samples <= 6'h00;
			o_temp_samples  <= 3'h0;
			o_result_store  <= 1'b0;
		end else begin
			o_conv_active   <= (next_state == ST_MEASURE);
			o_press_samples <= psmc_press_os(pavg);
			o_temp_samples  <= psmc_temp_os(pavg);
			o_result_store  <= meas_end && !mode_wr;
		end
	end

	// Measuring bit follows the conversion and drops with the store
	always @(posedge i_ref_clk) begin
		if (any_rst) begin
			o_status_reg <= 8'h00;
		end else begin
			o_status_reg <= 8'h00;
			o_status_reg[`PSMC_MEASURING_BIT] <= (next_state == ST_MEASURE);
			o_status_reg[`PSMC_NVM_BUSY_BIT]  <= i_nvm_access;
		end
	end

endmodule
`default_nettype wire

// ### test/psmc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks for the mode control block
// ****************************************
module psmc_chk #(
	parameter [1:0] MODE_SLEEP  = 2'h0,
	parameter [1:0] MODE_FORCED = 2'h1
) (
	// Clock and resets
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_async_rst_pin_n,
	// Inputs watched
	input wire logic       i_addr_select_dout_pin,
	input wire logic       i_meas_ctrl_wr,
	input wire logic [7:0] i_meas_ctrl_data,
	input wire logic       i_filter_wr,
	input wire logic [2:0] i_filter_data,
	// Outputs watched
	input wire logic       o_spi_mode,
	input wire logic       o_spi_3wire,
	input wire logic [6:0] o_i2c_addr,
	input wire logic [7:0] o_io_setup_reg,
	input wire logic [7:0] o_measurement_control_reg,
	input wire logic [7:0] o_status_reg,
	input wire logic [2:0] o_filter_coef,
	input wire logic       o_conv_active,
	input wire logic       o_result_store
);
	reg  [7:0] pin_low;
	wire       quiet;
	wire [1:0] mode;
	// Pin reset lands late through its filter, so checks rest a while after it
	always @(posedge i_ref_clk) begin
		if (i_rst)
			pin_low <= 8'h00;
		else
			pin_low <= {pin_low[6:0], ~i_async_rst_pin_n};
	end
	assign quiet = (pin_low == 8'h00) && i_async_rst_pin_n;
	assign mode  = o_measurement_control_reg[1:0];
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst || !quiet);
	// Properties
	reset_image_a: assert property (disable iff (!quiet) i_rst |=>
		!o_spi_mode && o_i2c_addr == 7'h70 && o_filter_coef == 3'h0) else $error("reset image");
	spi_latch_a: assert property (o_spi_mode |=> o_spi_mode)
		else $error("spi mode lost");
	addr_pick_a: assert property ((!o_spi_mode && $stable(i_addr_select_dout_pin))[*6]
		|-> o_i2c_addr == (i_addr_select_dout_pin ? 7'h56 : 7'h70)) else $error("i2c addr");
	wire_mode_a: assert property (!$past(i_rst) |->
		o_spi_3wire == $past(o_spi_mode && o_io_setup_reg[0]))
		else $error("wire mode");
	ctrl_write_a: assert property (i_meas_ctrl_wr |=>
		o_measurement_control_reg == $past(i_meas_ctrl_data)) else $error("ctrl write");
	filter_write_a: assert property (i_filter_wr |=> o_filter_coef ==
		($past(i_filter_data) > 3'h5 ? 3'h0 : $past(i_filter_data))) else $error("filter");
	status_meas_a: assert property (o_status_reg[3] == o_conv_active &&
		o_status_reg[7:4] == 4'h0 && o_status_reg[2:1] == 2'h0)
		else $error("measuring flag");
	store_pulse_a: assert property (o_result_store |->
		$past(o_conv_active) && !o_conv_active ##1 !o_result_store) else $error("store");
	forced_back_a: assert property (o_result_store && mode == MODE_FORCED && !i_meas_ctrl_wr &&
		!$past(i_meas_ctrl_wr) |=> mode == MODE_SLEEP) else $error("forced return");
	sleep_idle_a: assert property (!o_conv_active && mode == MODE_SLEEP && !i_meas_ctrl_wr
		|=> !o_conv_active) else $error("conversion in sleep");
	// Main scenarios seen
	cover property (o_result_store && mode == MODE_FORCED);
	cover property (o_result_store && mode != MODE_FORCED);
	cover property ($rose(o_spi_mode));
endmodule
bind psmc_mode_control psmc_chk #(.MODE_SLEEP(MODE_SLEEP), .MODE_FORCED(MODE_FORCED)) psmc_chk_inst (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_async_rst_pin_n(i_async_rst_pin_n),
	.i_addr_select_dout_pin(i_addr_select_dout_pin), .i_meas_ctrl_wr(i_meas_ctrl_wr),
	.i_meas_ctrl_data(i_meas_ctrl_data), .i_filter_wr(i_filter_wr), .i_filter_data(i_filter_data),
	.o_spi_mode(o_spi_mode), .o_spi_3wire(o_spi_3wire), .o_i2c_addr(o_i2c_addr),
	.o_io_setup_reg(o_io_setup_reg), .o_measurement_control_reg(o_measurement_control_reg),
	.o_status_reg(o_status_reg), .o_filter_coef(o_filter_coef),
	.o_conv_active(o_conv_active), .o_result_store(o_result_store));
`default_nettype wire

// ### test/psmc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side: pins and register writes
// ****************************************
module psmc_host (
	// Clock
	input  wire logic       i_ref_clk,
	// Pins
	output var  logic       o_cs,
	output var  logic       o_adr,
	// Writes: bit 0 setup, 1 control, 2 filter
	output var  logic [2:0] o_wr,
	output var  logic [7:0] o_dat
);
	// Idle with the port in I2C
	initial begin
		o_cs  = 1'b1;
		o_adr = 1'b0;
		o_wr  = 3'h0;
		o_dat = 8'h00;
	end
	// Pin levels move just after an edge
	task pin(input logic c, input logic a);
		@(posedge i_ref_clk) #1;
		o_cs  = c;
		o_adr = a;
	endtask
	// One-cycle strobe; data inverted after so a stale byte never matches
	task wr(input int k, input logic [7:0] d);
		@(posedge i_ref_clk) #1;
		o_wr[k] = 1'b1;
		o_dat   = d;
		@(posedge i_ref_clk) #1;
		o_wr  = 3'h0;
		o_dat = ~d;
	endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Mode control testbench
// ****************************************
module tb_top;
	localparam int   TK = 2;
	logic            i_ref_clk, i_rst, rst_n, nvm;
	wire logic       cs, adr, spi, s3w, otyp, conv, store;
	wire logic [2:0] wr, fc, ts;
	wire logic [5:0] ps;
	wire logic [6:0] a7;
	wire logic [7:0] dat, io_r, mc_r, st_r;
	int              err_count = 0, n_compared = 0, nst = 0, i, s, g, c, q;
	int              mp[8] = '{0, 2, 4, 8, 16, 32, 0, 0};
	int              mt[8] = '{0, 1, 1, 1, 2, 4, 0, 0};
	// Short counts so normal-mode standby stays brief
	psmc_mode_control #(.SAMPLE_TICKS(16'h0001), .STBY_BASE_TICKS(16'h0001),
		.TICK_CYCLES(8'h02)) psmc_mode_control_inst (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_async_rst_pin_n(rst_n),
		.i_chip_select_pin(cs), .i_addr_select_dout_pin(adr), .i_io_setup_wr(wr[0]),
		.i_io_setup_data(dat), .i_meas_ctrl_wr(wr[1]), .i_meas_ctrl_data(dat),
		.i_filter_wr(wr[2]), .i_filter_data(dat[2:0]), .i_nvm_access(nvm),
		.o_spi_mode(spi), .o_spi_3wire(s3w), .o_data_pin_output_type(otyp), .o_i2c_addr(a7),
		.o_io_setup_reg(io_r), .o_measurement_control_reg(mc_r), .o_status_reg(st_r),
		.o_filter_coef(fc), .o_conv_active(conv), .o_press_samples(ps),
		.o_temp_samples(ts), .o_result_store(store));
	psmc_host psmc_host_inst (.i_ref_clk(i_ref_clk), .o_cs(cs), .o_adr(adr), .o_wr(wr), .o_dat(dat));
	// Clock, stores seen by the host, and a hang limit
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) if (store === 1'b1) nst++;
	initial begin
		#500000;
		err_count++;
		give_verdict;
	end
	// Shared helpers
	task cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t got %0h exp %0h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("n_compared %0d err_count %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Wait for a conversion, check its sample pair, return its length
	task meas(input int p, output int n);
		int k;
		n = 0;
		for (k = 0; k < 400 && conv !== 1'b1; k++) cyc(1);
		if (k == 400) begin err_count++; give_verdict; end
		chk({ps, ts}, {mp[p][5:0], mt[p][2:0]});
		while (conv === 1'b1 && n < 400) begin n++; cyc(1); end
	endtask
	// Main sequence
	initial begin
		i_rst = 1'b1;
		rst_n = 1'b1;
		nvm   = 1'b0;
		q     = $urandom(32'h2af6);
		cyc(5);
		i_rst = 1'b0;
		chk({spi, a7, mc_r, io_r, fc}, {1'b0, 7'h70, 16'h0000, 3'h0});
		for (i = 0; i < 2; i++) begin
			psmc_host_inst.pin(1'b1, i[0]);
			cyc(6);
			chk(a7, i ? 7'h56 : 7'h70);
		end
		nvm = $urandom;
		cyc(2);
		chk(st_r, {7'h00, nvm});
		for (i = 0; i < 8; i++) begin
			psmc_host_inst.wr(2, i);
			chk(fc, i > 5 ? 0 : i);
		end
		g = $urandom;
		psmc_host_inst.wr(0, g);
		cyc(1);
		chk({io_r, otyp, s3w}, {g[7:0], g[2], 1'b0});
		for (s = 1; s < 6; s++) begin
			g = $urandom;
			psmc_host_inst.wr(1, {g[2:0], s[2:0], 2'h1});
			meas(s, c);
			chk(c >= (mp[s] + mt[s]) * TK && c <= (mp[s] + mt[s] + 1) * TK + 1, 1);
			cyc(1);
			chk(mc_r, {g[2:0], s[2:0], 2'h0});
		end
		cyc(30);
		chk({conv, nst}, {1'b0, 32'd5});
		for (s = 0; s < 8; s++) begin
			psmc_host_inst.wr(0, {s[2:0], 5'h00});
			psmc_host_inst.wr(1, 8'h17);
			meas(5, c);
			for (g = 0; g < 600 && conv !== 1'b1; g++) cyc(1);
			chk(g >= (1 << s) * TK && g <= ((1 << s) + 2) * TK + 1, 1);
			q = nst;
			psmc_host_inst.wr(1, 8'h14);
			cyc(4);
			chk({conv, nst}, {1'b0, q});
		end
		psmc_host_inst.pin(1'b0, 1'b1);
		cyc(8);
		chk(spi, 1);
		psmc_host_inst.pin(1'b1, 1'b0);
		cyc(8);
		chk({spi, a7}, {1'b1, 7'h56});
		for (i = 0; i < 2; i++) begin
			psmc_host_inst.wr(0, i);
			cyc(1);
			chk(s3w, i);
		end
		i_rst = 1'b1;
		cyc(1);
		i_rst = 1'b0;
		chk(spi, 0);
		cyc(8);
		chk({spi, a7}, {1'b0, 7'h70});
		psmc_host_inst.pin(1'b0, 1'b0);
		cyc(8);
		psmc_host_inst.pin(1'b1, 1'b0);
		rst_n = 1'b0;
		cyc(6);
		rst_n = 1'b1;
		cyc(10);
		chk(spi, 0);
		give_verdict;
	end
endmodule
`default_nettype wire
